/* dv/mac_link_model.sv */
// MAC side of the RGMII link: drives speed code and transmit error on the link clock.
// Assumes the bench sets the requested levels; they reach the block at the next link edge.
`timescale 1ns/1ps
module mac_link_model (
    input  wire logic       i_clk_link,
    input  wire logic [1:0] i_speed_req,
    input  wire logic       i_err_req,
    output logic [1:0]      o_link_speed,
    output logic            o_mac_tx_er
);
    // A real MAC launches from its own transmit clock, so requests wait for a link edge
    always_ff @(posedge i_clk_link)
    begin
        o_link_speed <= i_speed_req;
        o_mac_tx_er  <= i_err_req;
    end
endmodule

/* dv/tb_top.sv */
// Register and link-output tests for the RGMII FIFO and clock control bank.
// Assumes AXI4-Lite slave timing as handed over and a free-running 12 ns link clock.
`timescale 1ns/1ps
module tb_top;
    import rgmii_ctrl_pkg::*;
    logic              i_clk_sys, i_clk_link, i_nrst;
    logic [ADDR_W-1:0] i_awaddr, i_araddr;
    logic              i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [31:0]       i_wdata;
    logic [3:0]        i_wstrb;
    logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]        o_bresp, o_rresp, spd, speed_req;
    logic [31:0]       o_rdata;
    logic              mac_er, err_req, o_line_tx_er, o_sup, o_txa, o_rxa, o_rec;
    logic [2:0]        o_rthr, o_tthr;
    logic [1:0]        resp;
    logic [31:0]       rd;
    int                n_fail, n_compared;
    localparam logic [ADDR_W-1:0] A_CTRL  = {IDX_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] A_CTRL2 = {IDX_CTRL2, 2'b00};
    localparam logic [ADDR_W-1:0] A_MODE  = {IDX_RX_MODE, 2'b00};
    localparam logic [ADDR_W-1:0] A_STAT  = {IDX_STATUS, 2'b00};
    localparam logic [8:0]        SAVE [4] = '{SAVE_NS_10M, SAVE_NS_100M, SAVE_NS_1G, 9'h000};

    rgmii_fifo_clock_control DUT (
        .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
        .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
        .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .i_clk_link(i_clk_link),
        .i_link_speed(spd), .i_mac_tx_er(mac_er), .o_line_tx_er(o_line_tx_er),
        .o_receive_sync_fifo_threshold(o_rthr), .o_transmit_sync_fifo_threshold(o_tthr),
        .o_transmit_error_suppress_enable(o_sup), .o_tx_clk_aligned(o_txa),
        .o_rx_clk_aligned(o_rxa), .o_rx_recovered_mode(o_rec));
    mac_link_model MAC (.i_clk_link(i_clk_link), .i_speed_req(speed_req), .i_err_req(err_req),
        .o_link_speed(spd), .o_mac_tx_er(mac_er));

    initial
    begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    initial
    begin
        i_clk_link = 1'b0;
        #3.7;
        forever #6 i_clk_link = ~i_clk_link;
    end

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Each transfer starts on a fresh edge so no signal is assigned twice in one step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
        logic aw_done, w_done;
        @(posedge i_clk_sys);
        aw_done = 1'b0;
        w_done  = 1'b0;
        i_awaddr <= a; i_awvalid <= 1'b1; i_wdata <= d; i_wstrb <= s;
        i_wvalid <= 1'b1; i_bready <= 1'b1;
        forever
        begin
            @(posedge i_clk_sys);
            if (aw_done && w_done && o_bvalid === 1'b1)
            begin
                resp = o_bresp;
                i_bready <= 1'b0;
                break;
            end
            if (!aw_done && o_awready === 1'b1)
            begin
                aw_done = 1'b1;
                i_awvalid <= 1'b0;
            end
            if (!w_done && o_wready === 1'b1)
            begin
                w_done = 1'b1;
                i_wvalid <= 1'b0;
            end
        end
    endtask
    task automatic rdr(input logic [ADDR_W-1:0] a);
        logic ar_done;
        @(posedge i_clk_sys);
        ar_done = 1'b0;
        i_araddr <= a; i_arvalid <= 1'b1; i_rready <= 1'b1;
        forever
        begin
            @(posedge i_clk_sys);
            if (ar_done && o_rvalid === 1'b1)
            begin
                rd = o_rdata;
                resp = o_rresp;
                i_rready <= 1'b0;
                break;
            end
            if (!ar_done && o_arready === 1'b1)
            begin
                ar_done = 1'b1;
                i_arvalid <= 1'b0;
            end
        end
    endtask
    task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [15:0] e);
        rdr(a);
        chk_val(what, {16'h0000, e}, rd);
        chk_val("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
    endtask
    // The crossing takes up to six link edges; twelve leaves margin
    task automatic settle();
        repeat (12) @(posedge i_clk_link);
    endtask
    task automatic cfg(input logic [2:0] rt, input logic [2:0] tt, input logic su,
                       input logic ta, input logic ra, input logic rc);
        chk_val("rx_thr", {29'h0, rt}, {29'h0, o_rthr});
        chk_val("tx_thr", {29'h0, tt}, {29'h0, o_tthr});
        chk_bit("suppress", su, o_sup);
        chk_bit("tx_aligned", ta, o_txa);
        chk_bit("rx_aligned", ra, o_rxa);
        chk_bit("recovered", rc, o_rec);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        n_fail++;
        conclude();
    end

    initial
    begin
        n_fail = 0; n_compared = 0; i_nrst = 1'b0;
        i_awaddr = '0; i_awvalid = 1'b0; i_wdata = '0; i_wstrb = '0; i_wvalid = 1'b0;
        i_bready = 1'b0; i_araddr = '0; i_arvalid = 1'b0; i_rready = 1'b0;
        speed_req = SPEED_1G; err_req = 1'b0;
        repeat (16) @(posedge i_clk_sys);
        i_nrst <= 1'b1;
        settle();
        cfg(3'h2, 3'h2, 1'b0, 1'b0, 1'b0, 1'b1);
        rd_chk("ctrl", A_CTRL, CTRL_RESET);
        rd_chk("ctrl2", A_CTRL2, CTRL2_RESET);
        rd_chk("rx_mode", A_MODE, RX_MODE_RESET);
        // Lane 0 strobe only: upper byte must keep its value
        wr(A_CTRL, 32'hFFFF_FFFF, 4'h1);
        settle();
        rd_chk("ctrl_lane0", A_CTRL, 16'h00FF);
        cfg(3'h3, 3'h3, 1'b1, 1'b1, 1'b1, 1'b1);
        wr(A_CTRL, 32'h0000_FFFF, 4'h3);
        rd_chk("ctrl_full", A_CTRL, 16'hFFFF & CTRL_WMASK);
        wr(A_CTRL2, 32'h0000_0004, 4'h3);
        rd_chk("ctrl2_msb", A_CTRL2, 16'h0004);
        for (int k = 0; k < 4; k++)
        begin
            wr(A_CTRL, {28'h0, 4'h0} | 32'h0048 | k, 4'h3);
            settle();
            cfg(3'h6, 3'h5, 1'b0, k[1], k[0], 1'b1);
        end
        wr(A_CTRL, 32'h0000_0004, 4'h3);
        err_req <= 1'b1;
        settle();
        chk_bit("line_er_suppressed", 1'b0, o_line_tx_er);
        wr(A_CTRL, 32'h0000_0000, 4'h3);
        settle();
        chk_bit("line_er_passed", 1'b1, o_line_tx_er);
        err_req <= 1'b0;
        settle();
        chk_bit("line_er_clear", 1'b0, o_line_tx_er);
        wr(A_CTRL2, 32'h0000_0000, 4'h3);
        wr(A_CTRL, 32'h0000_0020, 4'h3);
        for (int s = 0; s < 4; s++)
        begin
            @(posedge i_clk_sys);
            speed_req <= s[1:0];
            settle();
            rdr(A_STAT);
            chk_val("saving", {23'h0, SAVE[s]}, {23'h0, rd[8:0]});
        end
        @(posedge i_clk_sys);
        speed_req <= SPEED_1G;
        wr(A_CTRL, 32'h0000_0040, 4'h3);
        settle();
        rdr(A_STAT);
        chk_val("saving_thr2", 32'h0, {23'h0, rd[8:0]});
        wr(A_CTRL, 32'h0000_0020, 4'h3);
        wr(A_MODE, 32'h0000_0010, 4'h3);
        chk_val("bresp_ok", {30'h0, RESP_OKAY}, {30'h0, resp});
        settle();
        rd_chk("rx_mode_set", A_MODE, 16'h0010);
        chk_bit("recovered_off", 1'b0, o_rec);
        rdr(A_STAT);
        chk_val("saving_direct", 32'h0, {23'h0, rd[8:0]});
        // Unmapped place: refused, nothing read back
        wr(12'h004, 32'h0000_FFFF, 4'h3);
        chk_val("bresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
        rdr(12'h004);
        chk_val("rresp_unmapped", {30'h0, RESP_SLVERR}, {30'h0, resp});
        chk_val("rdata_unmapped", 32'h0, rd);
        rd_chk("ctrl_kept", A_CTRL, 16'h0020);
        conclude();
    end
endmodule

/* rtl/rgmii_ctrl_pkg.sv */
// Constants for the RGMII FIFO and clock control register bank.
// Assumes a 32-bit AXI4-Lite register bus and 16-bit registers in the low lanes.
package rgmii_ctrl_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_CTRL          = 10'h032;
    localparam logic [9:0]  IDX_CTRL2         = 10'h033;
    localparam logic [9:0]  IDX_RX_MODE       = 10'h060;
    localparam logic [9:0]  IDX_STATUS        = 10'h061;
    localparam int          ADDR_W            = 12;
    localparam int          REG_W             = 16;

    localparam logic [15:0] CTRL_RESET        = 16'h00D0;
    localparam logic [15:0] CTRL2_RESET       = 16'h0000;
    localparam logic [15:0] RX_MODE_RESET     = 16'h0000;
    localparam logic [15:0] CTRL_WMASK        = 16'h0BFF;
    localparam logic [15:0] CTRL2_WMASK       = 16'h001F;
    localparam logic [15:0] RX_MODE_WMASK     = 16'h0010;

    // Field positions
    localparam int          RX_THR_LSB        = 5;
    localparam int          TX_THR_LSB        = 3;
    localparam int          TX_ERR_SUPP_BIT   = 2;
    localparam int          TX_CLK_ALIGN_BIT  = 1;
    localparam int          RX_CLK_ALIGN_BIT  = 0;
    localparam int          THR_MSB_BIT       = 2;
    localparam int          RX_MODE_BIT       = 4;
    localparam int          STATUS_SYNC_BIT   = 15;

    // Link speed codes and the receive latency saved at threshold 1
    localparam logic [1:0]  SPEED_10M         = 2'h0;
    localparam logic [1:0]  SPEED_100M        = 2'h1;
    localparam logic [1:0]  SPEED_1G          = 2'h2;
    localparam logic [8:0]  SAVE_NS_1G        = 9'h008;
    localparam logic [8:0]  SAVE_NS_100M      = 9'h028;
    localparam logic [8:0]  SAVE_NS_10M       = 9'h190;
    localparam logic [2:0]  THR_LOW           = 3'h1;

    // Link-side config word: {recovered, rx_thr, tx_thr, suppress, tx_align, rx_align}
    localparam int          CFG_W             = 10;
    localparam logic [9:0]  CFG_RESET         = 10'h290;

    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage

/* rtl/rgmii_fifo_clock_control.sv */
// RGMII FIFO threshold and clock skew control registers with link-side outputs.
// Assumes an AXI4-Lite master on i_clk_sys and RGMII logic on i_clk_link.
`timescale 1ns/1ps
module rgmii_fifo_clock_control
    import rgmii_ctrl_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_nrst,
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    input  wire logic              i_clk_link,
    input  wire logic [1:0]        i_link_speed,
    input  wire logic              i_mac_tx_er,
    output logic                   o_line_tx_er,
    output logic [2:0]             o_receive_sync_fifo_threshold,
    output logic [2:0]             o_transmit_sync_fifo_threshold,
    output logic                   o_transmit_error_suppress_enable,
    output logic                   o_tx_clk_aligned,
    output logic                   o_rx_clk_aligned,
    output logic                   o_rx_recovered_mode
);
    logic [15:0]      ctrl;
    logic [15:0]      ctrl2;
    logic [15:0]      rx_mode;
    logic [8:0]       saving_ns;
    logic             aw_held;
    logic             w_held;
    logic [9:0]       aw_idx;
    logic [31:0]      w_data;
    logic [3:0]       w_strb;
    logic [15:0]      next_ctrl;
    logic [15:0]      next_ctrl2;
    logic [15:0]      next_rx_mode;
    logic [8:0]       next_saving_ns;
    logic             next_aw_held;
    logic             next_w_held;
    logic [9:0]       next_aw_idx;
    logic [31:0]      next_w_data;
    logic [3:0]       next_w_strb;
    logic             next_bvalid;
    logic [1:0]       next_bresp;
    logic             next_rvalid;
    logic [31:0]      next_rdata;
    logic [1:0]       next_rresp;
    logic             wr_fire;
    logic [9:0]       ar_idx;
    logic [2:0]       receive_sync_fifo_threshold;
    logic [2:0]       transmit_sync_fifo_threshold;
    logic             rx_recovered;
    logic [CFG_W-1:0] cfg_sys;
    logic             cfg_in_sync;
    logic [1:0]       speed_sys;
    logic             speed_in_sync;
    logic             nrst_link_s1;
    logic             nrst_link;
    logic [CFG_W-1:0] cfg_link;
    logic             cfg_update;
    logic             tx_er_s1;
    logic             tx_er_s2;
    logic             next_line_tx_er;

    // Merge byte lanes, then keep read-only bits at their old value
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] upd;
        upd = old;
        if (strb[0])
        begin
            upd[7:0] = data[7:0];
        end
        if (strb[1])
        begin
            upd[15:8] = data[15:8];
        end
        return (upd & mask) | (old & ~mask);
    endfunction

    // Both thresholds take their top bit from the same extended control bit
    assign receive_sync_fifo_threshold  = {ctrl2[THR_MSB_BIT], ctrl[RX_THR_LSB +: 2]};
    assign transmit_sync_fifo_threshold = {ctrl2[THR_MSB_BIT], ctrl[TX_THR_LSB +: 2]};
    assign rx_recovered = ~rx_mode[RX_MODE_BIT];
    assign cfg_sys = {rx_recovered, receive_sync_fifo_threshold, transmit_sync_fifo_threshold,
                      ctrl[TX_ERR_SUPP_BIT], ctrl[TX_CLK_ALIGN_BIT], ctrl[RX_CLK_ALIGN_BIT]};
    assign wr_fire = aw_held && w_held && !o_bvalid;
    assign ar_idx  = i_araddr[ADDR_W-1:2];

    // Write channel; address and data may arrive in either order
    always_comb
    begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_idx  = aw_idx;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = o_bvalid;
        next_bresp   = o_bresp;
        next_ctrl    = ctrl;
        next_ctrl2   = ctrl2;
        next_rx_mode = rx_mode;
        if (o_bvalid && i_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (i_awvalid && o_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_idx  = i_awaddr[ADDR_W-1:2];
        end
        if (i_wvalid && o_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = i_wdata;
            next_w_strb = i_wstrb;
        end
        if (wr_fire)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = RESP_OKAY;
            unique case (aw_idx)
                IDX_CTRL:    next_ctrl    = merge(ctrl, w_data, w_strb, CTRL_WMASK);
                IDX_CTRL2:   next_ctrl2   = merge(ctrl2, w_data, w_strb, CTRL2_WMASK);
                IDX_RX_MODE: next_rx_mode = merge(rx_mode, w_data, w_strb, RX_MODE_WMASK);
                IDX_STATUS:  next_bresp   = RESP_OKAY;
                default:     next_bresp   = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            aw_idx    <= 10'h000;
            w_data    <= 32'h0000_0000;
            w_strb    <= 4'h0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
            o_bvalid  <= 1'b0;
            o_bresp   <= RESP_OKAY;
            ctrl      <= CTRL_RESET;
            ctrl2     <= CTRL2_RESET;
            rx_mode   <= RX_MODE_RESET;
        end
        else
        begin
            aw_held   <= next_aw_held;
            w_held    <= next_w_held;
            aw_idx    <= next_aw_idx;
            w_data    <= next_w_data;
            w_strb    <= next_w_strb;
            o_awready <= !next_aw_held;
            o_wready  <= !next_w_held;
            o_bvalid  <= next_bvalid;
            o_bresp   <= next_bresp;
            ctrl      <= next_ctrl;
            ctrl2     <= next_ctrl2;
            rx_mode   <= next_rx_mode;
        end
    end

    // Read channel and the latency saving shown in the status register
    always_comb
    begin
        next_rvalid    = o_rvalid;
        next_rdata     = o_rdata;
        next_rresp     = o_rresp;
        next_saving_ns = 9'h000;
        if (rx_recovered && (receive_sync_fifo_threshold == THR_LOW))
        begin
            unique case (speed_sys)
                SPEED_1G:   next_saving_ns = SAVE_NS_1G;
                SPEED_100M: next_saving_ns = SAVE_NS_100M;
                SPEED_10M:  next_saving_ns = SAVE_NS_10M;
                default:    next_saving_ns = 9'h000;
            endcase
        end
        if (o_rvalid && i_rready)
        begin
            next_rvalid = 1'b0;
        end
        if (i_arvalid && o_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp  = RESP_OKAY;
            unique case (ar_idx)
                IDX_CTRL:    next_rdata = {16'h0000, ctrl};
                IDX_CTRL2:   next_rdata = {16'h0000, ctrl2};
                IDX_RX_MODE: next_rdata = {16'h0000, rx_mode};
                IDX_STATUS:  next_rdata = {16'h0000, cfg_in_sync && speed_in_sync,
                                           6'h00, saving_ns};
                default:
                begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_nrst)
        begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= RESP_OKAY;
            saving_ns <= 9'h000;
        end
        else
        begin
            o_arready <= !next_rvalid;
            o_rvalid  <= next_rvalid;
            o_rdata   <= next_rdata;
            o_rresp   <= next_rresp;
            saving_ns <= next_saving_ns;
        end
    end

    // Link reset: the link clock must run while i_nrst is low
    always_ff @(posedge i_clk_link)
    begin
        nrst_link_s1 <= i_nrst;
        nrst_link    <= nrst_link_s1;
    end

    word_crossing #(.W(CFG_W), .INIT(CFG_RESET)) cfg_cross (
        .i_clk_src  (i_clk_sys),
        .i_nrst_src (i_nrst),
        .i_data     (cfg_sys),
        .o_in_sync  (cfg_in_sync),
        .i_clk_dst  (i_clk_link),
        .i_nrst_dst (nrst_link),
        .o_data     (cfg_link),
        .o_update   (cfg_update)
    );

    word_crossing #(.W(2), .INIT(SPEED_10M)) speed_cross (
        .i_clk_src  (i_clk_link),
        .i_nrst_src (nrst_link),
        .i_data     (i_link_speed),
        .o_in_sync  (),
        .i_clk_dst  (i_clk_sys),
        .i_nrst_dst (i_nrst),
        .o_data     (speed_sys),
        .o_update   (speed_in_sync)
    );

    // Error suppression acts on the synchronised MAC error; MAC error to line error takes three link cycles
    always_comb
    begin
        next_line_tx_er = tx_er_s2 && !cfg_link[2];
    end

    always_ff @(posedge i_clk_link)
    begin
        if (!nrst_link)
        begin
            tx_er_s1                         <= 1'b0;
            tx_er_s2                         <= 1'b0;
            o_line_tx_er                     <= 1'b0;
            o_rx_recovered_mode              <= CFG_RESET[9];
            o_receive_sync_fifo_threshold    <= CFG_RESET[8:6];
            o_transmit_sync_fifo_threshold   <= CFG_RESET[5:3];
            o_transmit_error_suppress_enable <= CFG_RESET[2];
            o_tx_clk_aligned                 <= CFG_RESET[1];
            o_rx_clk_aligned                 <= CFG_RESET[0];
        end
        else
        begin
            tx_er_s1                         <= i_mac_tx_er;
            tx_er_s2                         <= tx_er_s1;
            o_line_tx_er                     <= next_line_tx_er;
            o_rx_recovered_mode              <= cfg_link[9];
            o_receive_sync_fifo_threshold    <= cfg_link[8:6];
            o_transmit_sync_fifo_threshold   <= cfg_link[5:3];
            o_transmit_error_suppress_enable <= cfg_link[2];
            o_tx_clk_aligned                 <= cfg_link[1];
            o_rx_clk_aligned                 <= cfg_link[0];
        end
    end

    a_ctrl_reset_value: assert property (@(posedge i_clk_sys)
        $rose(i_nrst) |-> (ctrl == CTRL_RESET) && (transmit_sync_fifo_threshold == 3'h2))
        else $error("control register reset value wrong");

    a_rx_thr_write: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        wr_fire && (aw_idx == IDX_CTRL) && w_strb[0]
        |=> receive_sync_fifo_threshold[1:0] == $past(w_data[6:5]))
        else $error("receive threshold low bits not written");

    a_rx_mode_default: assert property (@(posedge i_clk_sys)
        $rose(i_nrst) |-> rx_recovered && !o_bvalid)
        else $error("receive path not recovered after reset");

    a_saving_gig: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        rx_recovered && (receive_sync_fifo_threshold == THR_LOW) && (speed_sys == SPEED_1G)
        |=> saving_ns == SAVE_NS_1G)
        else $error("gigabit latency saving wrong");

    a_tx_skew_apply: assert property (@(posedge i_clk_link) disable iff (!nrst_link)
        cfg_update |=> ##1 o_tx_clk_aligned == $past(cfg_link[1], 1))
        else $error("transmit skew select not applied");

    a_rx_skew_apply: assert property (@(posedge i_clk_link) disable iff (!nrst_link)
        cfg_update ##1 !cfg_update |=> o_rx_clk_aligned == $past(cfg_link[0], 1))
        else $error("receive skew select not applied");

    a_tx_er_block: assert property (@(posedge i_clk_link) disable iff (!nrst_link)
        (tx_er_s2 && cfg_link[2]) |=> !o_line_tx_er)
        else $error("suppressed transmit error reached line");

    a_tx_er_pass: assert property (@(posedge i_clk_link) disable iff (!nrst_link)
        (tx_er_s2 && !cfg_link[2]) |=> o_line_tx_er)
        else $error("transmit error lost while not suppressed");

    a_bvalid_hold: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
        o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped before handshake");
endmodule

/* rtl/word_crossing.sv */
// Toggle-handshake crossing of a slowly changing word between two clocks.
// Assumes the source word stays stable for a full handshake to be seen whole.
`timescale 1ns/1ps
module word_crossing #(
    parameter int               W       = 8,
    parameter logic [W-1:0]     INIT    = '0
) (
    input  wire logic           i_clk_src,
    input  wire logic           i_nrst_src,
    input  wire logic [W-1:0]   i_data,
    output logic                o_in_sync,
    input  wire logic           i_clk_dst,
    input  wire logic           i_nrst_dst,
    output logic [W-1:0]        o_data,
    output logic                o_update
);
    logic [W-1:0] sent;
    logic         req;
    logic         ack_s1;
    logic         ack_s2;
    logic [W-1:0] next_sent;
    logic         next_req;
    logic         req_s1;
    logic         req_s2;
    logic         req_s3;
    logic [W-1:0] next_data;

    // Source side: a new word leaves only once the previous one was acknowledged
    always_comb
    begin
        next_sent = sent;
        next_req  = req;
        if ((req == ack_s2) && (i_data != sent))
        begin
            next_sent = i_data;
            next_req  = ~req;
        end
    end

    always_ff @(posedge i_clk_src)
    begin
        if (!i_nrst_src)
        begin
            sent      <= INIT;
            req       <= 1'b0;
            ack_s1    <= 1'b0;
            ack_s2    <= 1'b0;
            o_in_sync <= 1'b1;
        end
        else
        begin
            sent      <= next_sent;
            req       <= next_req;
            ack_s1    <= req_s3;
            ack_s2    <= ack_s1;
            o_in_sync <= (req == ack_s2) && (i_data == sent);
        end
    end

    // Destination side: the word is read only after the toggle has settled
    always_comb
    begin
        next_data = o_data;
        if (req_s2 != req_s3)
        begin
            next_data = sent;
        end
    end

    always_ff @(posedge i_clk_dst)
    begin
        if (!i_nrst_dst)
        begin
            req_s1   <= 1'b0;
            req_s2   <= 1'b0;
            req_s3   <= 1'b0;
            o_data   <= INIT;
            o_update <= 1'b0;
        end
        else
        begin
            req_s1   <= req;
            req_s2   <= req_s1;
            req_s3   <= req_s2;
            o_data   <= next_data;
            o_update <= (req_s2 != req_s3);
        end
    end
endmodule
